/* logic/lpw_pkg.sv */
// constants of the low-power mode and wake-up controller
// assumes an apb master on pclk and peripheral wake sources in pclk domain
package lpw_pkg;
	typedef enum logic [2:0] {
		lpw_run, lpw_sleep, lpw_deep_sleep, lpw_power_down, lpw_deep_pd
	} lpw_state_e;

	localparam logic [11:0] ADDR_MODE = 12'h000;
	localparam logic [11:0] ADDR_SLEEP_CFG = 12'h004;
	localparam logic [11:0] ADDR_DPD_CTRL = 12'h008;
	localparam logic [11:0] ADDR_PIN_WAKE = 12'h00C;
	localparam logic [11:0] ADDR_PERIPH_WAKE = 12'h010;
	localparam logic [11:0] ADDR_BROWNOUT = 12'h014;
	localparam logic [11:0] ADDR_WDT_MODE = 12'h018;
	localparam logic [11:0] ADDR_WKT_CTRL = 12'h01C;
	localparam logic [11:0] ADDR_WKT_COUNT = 12'h020;
	localparam logic [11:0] ADDR_CLK_SEL = 12'h024;
	localparam logic [11:0] ADDR_STATUS = 12'h028;

	// mode field encoding
	localparam logic [1:0] MODE_SLEEP = 2'h0;
	localparam logic [1:0] MODE_DEEP_SLEEP = 2'h1;
	localparam logic [1:0] MODE_POWER_DOWN = 2'h2;
	localparam logic [1:0] MODE_DEEP_PD = 2'h3;

	// sleep_power_config bits: 1 keeps block powered in sleep; deep sleep and power-down read only bod and low-power oscillator
	localparam int CFG_BOD = 0;
	localparam int CFG_LOW_POWER_OSCILLATOR = 1;
	localparam int CFG_FRO = 2;
	localparam int CFG_FRO_OUT = 3;
	localparam int CFG_FLASH = 4;
	localparam int CFG_PLL = 5;
	localparam int CFG_XTAL = 6;
	localparam int CFG_ADC = 7;
	localparam int CFG_CMP = 8;
	localparam int CFG_PERIPH = 9;
	localparam logic [9:0] SLEEP_CFG_RST = 10'h3FF;

	// deep_power_down_control bits
	localparam int DPD_WAKE_PIN = 0;
	localparam int DPD_RESET_PIN = 1;
	localparam int DPD_LOW_POWER_OSCILLATOR_EN = 2;
	localparam int DPD_LOW_POWER_OSCILLATOR_KEEP = 3;
	localparam int DPD_LOCK = 4;

	// brownout_control, watchdog_mode_register, timer control bits
	localparam int BOD_IRQ_EN = 0;
	localparam int BOD_RST_EN = 1;
	localparam int WDT_EN = 0;
	localparam int WDT_IRQ_EN = 1;
	localparam int WDT_RST_EN = 2;
	localparam int WDT_FED = 3;
	localparam int WKT_LOW_CLK = 0;

	// clock select: 0 free-running oscillator after reset
	localparam logic [1:0] CLK_FRO = 2'h0;
	localparam logic [1:0] CLK_XTAL = 2'h1;
	localparam logic [1:0] CLK_EXT = 2'h2;
	localparam logic [1:0] CLK_PLL = 2'h3;

	// peripheral wake enable bit positions
	localparam int PW_BOD = 0;
	localparam int PW_WDT = 1;
	localparam int PW_WKT = 2;
	localparam int PW_SERIAL = 3;
endpackage

/* logic/lpw_sync.sv */
// two-flop synchroniser for asynchronous pins
// assumes pclk domain at the output
module lpw_sync #(
	parameter int WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

/* logic/lpw_ctrl.sv */
// low-power mode controller with wake-up source gating and apb registers
// assumes wake sources and interrupt enables are synchronous to pclk,
// wake and reset pins are asynchronous
module lpw_ctrl #(
	parameter int NPIN = 8,
	parameter int NIRQ = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic core_wfi,
	input wire logic [NIRQ-1:0] irq_pending,
	input wire logic [NIRQ-1:0] irq_enable,
	input wire logic [NPIN-1:0] pin_irq,
	input wire logic [NPIN-1:0] pin_irq_en,
	input wire logic bod_irq,
	input wire logic bod_irq_en,
	input wire logic bod_reset,
	input wire logic wdt_irq,
	input wire logic wdt_irq_en,
	input wire logic wkt_timeout,
	input wire logic wkt_irq_en,
	input wire logic serial_irq,
	input wire logic serial_irq_en,
	input wire logic wake_pin,
	input wire logic reset_pin_n,
	input wire logic reset_pin_func_en,
	input wire logic xtal_ready,
	input wire logic pll_locked,
	output logic core_clk_en,
	output logic periph_clk_en,
	output logic fro_en,
	output logic fro_out_en,
	output logic low_power_oscillator_en,
	output logic xtal_en,
	output logic pll_en,
	output logic flash_en,
	output logic flash_standby,
	output logic analog_en,
	output logic bod_en,
	output logic wkt_en,
	output logic wkt_start,
	output logic [1:0] main_clk_sel,
	output logic wake_reset
);
	lpw_pkg::lpw_state_e state, next_state;
	logic [1:0] mode, bod_ctrl, clk_req, pin_s;
	logic [9:0] sleep_cfg;
	logic [4:0] dpd_ctrl;
	logic [NPIN-1:0] pin_wake;
	logic [3:0] periph_wake, wdt_mode;
	logic [31:0] wkt_count;
	logic wkt_ctrl, dpd_refused, wr_en, rd_en, addr_ok;
	logic sleep_wake, dpd_wake, src_ok;

	lpw_sync #(
		.WIDTH(2)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({wake_pin, ~reset_pin_n}),
		.q(pin_s)
	);

	// ==========================================================
	// apb slave: zero wait, read data loaded at setup so it stands in access
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	always_comb
	begin
		case (paddr)
			lpw_pkg::ADDR_MODE, lpw_pkg::ADDR_SLEEP_CFG,
			lpw_pkg::ADDR_DPD_CTRL, lpw_pkg::ADDR_PIN_WAKE,
			lpw_pkg::ADDR_PERIPH_WAKE, lpw_pkg::ADDR_BROWNOUT,
			lpw_pkg::ADDR_WDT_MODE, lpw_pkg::ADDR_WKT_CTRL,
			lpw_pkg::ADDR_WKT_COUNT, lpw_pkg::ADDR_CLK_SEL,
			lpw_pkg::ADDR_STATUS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	assign pslverr = psel && penable && !addr_ok;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode <= lpw_pkg::MODE_SLEEP;
			sleep_cfg <= lpw_pkg::SLEEP_CFG_RST;
			dpd_ctrl <= '0;
			pin_wake <= '0;
			periph_wake <= '0;
			bod_ctrl <= '0;
			wdt_mode <= '0;
			wkt_ctrl <= 1'b0;
			wkt_count <= '0;
		end
		else if (wr_en)
		begin
			case (paddr)
				lpw_pkg::ADDR_MODE: mode <= pwdata[1:0];
				lpw_pkg::ADDR_SLEEP_CFG: sleep_cfg <= pwdata[9:0];
				lpw_pkg::ADDR_DPD_CTRL: dpd_ctrl <= pwdata[4:0];
				lpw_pkg::ADDR_PIN_WAKE: pin_wake <= pwdata[NPIN-1:0];
				lpw_pkg::ADDR_PERIPH_WAKE: periph_wake <= pwdata[3:0];
				lpw_pkg::ADDR_BROWNOUT: bod_ctrl <= pwdata[1:0];
				lpw_pkg::ADDR_WDT_MODE: wdt_mode <= pwdata[3:0];
				lpw_pkg::ADDR_WKT_CTRL: wkt_ctrl <= pwdata[0];
				lpw_pkg::ADDR_WKT_COUNT: wkt_count <= pwdata;
				default: ;
			endcase
		end
	end

	// timer starts on a count write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wkt_start <= 1'b0;
		else
			wkt_start <= wr_en && paddr == lpw_pkg::ADDR_WKT_COUNT;
	end

	// clock switch only once the target source is stable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clk_req <= lpw_pkg::CLK_FRO;
		else if (wr_en && paddr == lpw_pkg::ADDR_CLK_SEL)
			clk_req <= pwdata[1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			main_clk_sel <= lpw_pkg::CLK_FRO;
		else
		begin
			case (clk_req)
				lpw_pkg::CLK_XTAL, lpw_pkg::CLK_EXT:
					if (xtal_ready)
						main_clk_sel <= clk_req;
				lpw_pkg::CLK_PLL:
					if (pll_locked)
						main_clk_sel <= clk_req;
				default: main_clk_sel <= lpw_pkg::CLK_FRO;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (rd_en)
		begin
			case (paddr)
				lpw_pkg::ADDR_MODE: prdata <= {30'h0, mode};
				lpw_pkg::ADDR_SLEEP_CFG: prdata <= {22'h0, sleep_cfg};
				lpw_pkg::ADDR_DPD_CTRL: prdata <= {27'h0, dpd_ctrl};
				lpw_pkg::ADDR_PIN_WAKE: prdata <= 32'(pin_wake);
				lpw_pkg::ADDR_PERIPH_WAKE: prdata <= {28'h0, periph_wake};
				lpw_pkg::ADDR_BROWNOUT: prdata <= {30'h0, bod_ctrl};
				lpw_pkg::ADDR_WDT_MODE: prdata <= {28'h0, wdt_mode};
				lpw_pkg::ADDR_WKT_CTRL: prdata <= {31'h0, wkt_ctrl};
				lpw_pkg::ADDR_WKT_COUNT: prdata <= wkt_count;
				lpw_pkg::ADDR_CLK_SEL: prdata <= {28'h0, clk_req, main_clk_sel};
				lpw_pkg::ADDR_STATUS: prdata <= {28'h0, dpd_refused, state};
				default: prdata <= '0;
			endcase
		end
	end

	// ==========================================================
	// wake-up sources
	assign sleep_wake = |(irq_pending & irq_enable)
		|| (pin_s[0] && reset_pin_func_en);

	always_comb
	begin
		src_ok = 1'b0;
		if (|(pin_irq & pin_irq_en & pin_wake))
			src_ok = 1'b1;
		if (bod_irq && bod_irq_en && periph_wake[lpw_pkg::PW_BOD]
			&& bod_ctrl[lpw_pkg::BOD_IRQ_EN]
			&& sleep_cfg[lpw_pkg::CFG_BOD])
			src_ok = 1'b1;
		if (bod_reset && bod_ctrl[lpw_pkg::BOD_RST_EN]
			&& sleep_cfg[lpw_pkg::CFG_BOD])
			src_ok = 1'b1;
		if (wdt_irq && wdt_mode[lpw_pkg::WDT_EN] && wdt_mode[lpw_pkg::WDT_FED]
			&& sleep_cfg[lpw_pkg::CFG_LOW_POWER_OSCILLATOR]
			&& ((wdt_irq_en && periph_wake[lpw_pkg::PW_WDT]
			&& wdt_mode[lpw_pkg::WDT_IRQ_EN])
			|| wdt_mode[lpw_pkg::WDT_RST_EN]))
			src_ok = 1'b1;
		if (wkt_timeout && wkt_irq_en && periph_wake[lpw_pkg::PW_WKT]
			&& wkt_ctrl && dpd_ctrl[lpw_pkg::DPD_LOW_POWER_OSCILLATOR_EN])
			src_ok = 1'b1;
		// serial target depends on an external master clock
		if (serial_irq && serial_irq_en
			&& periph_wake[lpw_pkg::PW_SERIAL])
			src_ok = 1'b1;
		if (pin_s[0] && reset_pin_func_en)
			src_ok = 1'b1;
	end

	assign dpd_wake = (pin_s[1] && dpd_ctrl[lpw_pkg::DPD_WAKE_PIN])
		|| (pin_s[0] && dpd_ctrl[lpw_pkg::DPD_RESET_PIN])
		|| (wkt_timeout && wkt_ctrl && dpd_ctrl[lpw_pkg::DPD_LOW_POWER_OSCILLATOR_EN]
		&& dpd_ctrl[lpw_pkg::DPD_LOW_POWER_OSCILLATOR_KEEP]);

	// ==========================================================
	// mode sequencer
	always_comb
	begin
		next_state = state;
		case (state)
			lpw_pkg::lpw_run:
				if (core_wfi)
				begin
					case (mode)
						lpw_pkg::MODE_DEEP_SLEEP:
							next_state = lpw_pkg::lpw_deep_sleep;
						lpw_pkg::MODE_POWER_DOWN:
							next_state = lpw_pkg::lpw_power_down;
						lpw_pkg::MODE_DEEP_PD:
							if (!dpd_ctrl[lpw_pkg::DPD_LOCK])
								next_state = lpw_pkg::lpw_deep_pd;
							else
								next_state = lpw_pkg::lpw_sleep;
						default: next_state = lpw_pkg::lpw_sleep;
					endcase
				end
			lpw_pkg::lpw_sleep:
				if (sleep_wake)
					next_state = lpw_pkg::lpw_run;
			lpw_pkg::lpw_deep_sleep, lpw_pkg::lpw_power_down:
				if (src_ok)
					next_state = lpw_pkg::lpw_run;
			lpw_pkg::lpw_deep_pd:
				if (dpd_wake)
					next_state = lpw_pkg::lpw_run;
			default: next_state = lpw_pkg::lpw_run;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= lpw_pkg::lpw_run;
		else
			state <= next_state;
	end

	// locked request is recorded for software
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dpd_refused <= 1'b0;
		else if (state == lpw_pkg::lpw_run && core_wfi
			&& mode == lpw_pkg::MODE_DEEP_PD && dpd_ctrl[lpw_pkg::DPD_LOCK])
			dpd_refused <= 1'b1;
		else if (wr_en && paddr == lpw_pkg::ADDR_DPD_CTRL)
			dpd_refused <= 1'b0;
	end

	// wake from deep power-down restarts the chip
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wake_reset <= 1'b0;
		else
			wake_reset <= state == lpw_pkg::lpw_deep_pd && dpd_wake;
	end

	// ==========================================================
	// power and clock gating
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_clk_en <= 1'b1;
			periph_clk_en <= 1'b1;
			fro_en <= 1'b1;
			fro_out_en <= 1'b1;
			low_power_oscillator_en <= 1'b1;
			xtal_en <= 1'b0;
			pll_en <= 1'b0;
			flash_en <= 1'b1;
			flash_standby <= 1'b0;
			analog_en <= 1'b1;
			bod_en <= 1'b1;
			wkt_en <= 1'b0;
		end
		else
		begin
			wkt_en <= wkt_ctrl;
			case (next_state)
				lpw_pkg::lpw_sleep:
				begin
					core_clk_en <= 1'b0;
					periph_clk_en <= sleep_cfg[lpw_pkg::CFG_PERIPH];
					fro_en <= sleep_cfg[lpw_pkg::CFG_FRO];
					fro_out_en <= sleep_cfg[lpw_pkg::CFG_FRO_OUT];
					low_power_oscillator_en <= sleep_cfg[lpw_pkg::CFG_LOW_POWER_OSCILLATOR];
					xtal_en <= sleep_cfg[lpw_pkg::CFG_XTAL];
					pll_en <= sleep_cfg[lpw_pkg::CFG_PLL];
					flash_en <= sleep_cfg[lpw_pkg::CFG_FLASH];
					flash_standby <= 1'b0;
					analog_en <= sleep_cfg[lpw_pkg::CFG_ADC]
						|| sleep_cfg[lpw_pkg::CFG_CMP];
					bod_en <= sleep_cfg[lpw_pkg::CFG_BOD];
				end
				lpw_pkg::lpw_deep_sleep, lpw_pkg::lpw_power_down:
				begin
					core_clk_en <= 1'b0;
					periph_clk_en <= 1'b0;
					fro_en <= next_state == lpw_pkg::lpw_deep_sleep;
					fro_out_en <= 1'b0;
					low_power_oscillator_en <= sleep_cfg[lpw_pkg::CFG_LOW_POWER_OSCILLATOR];
					xtal_en <= 1'b0;
					pll_en <= 1'b0;
					flash_en <= next_state == lpw_pkg::lpw_deep_sleep;
					flash_standby <= next_state == lpw_pkg::lpw_deep_sleep;
					analog_en <= 1'b0;
					bod_en <= sleep_cfg[lpw_pkg::CFG_BOD];
				end
				lpw_pkg::lpw_deep_pd:
				begin
					core_clk_en <= 1'b0;
					periph_clk_en <= 1'b0;
					fro_en <= 1'b0;
					fro_out_en <= 1'b0;
					low_power_oscillator_en <= dpd_ctrl[lpw_pkg::DPD_LOW_POWER_OSCILLATOR_KEEP];
					xtal_en <= 1'b0;
					pll_en <= 1'b0;
					flash_en <= 1'b0;
					flash_standby <= 1'b0;
					analog_en <= 1'b0;
					bod_en <= 1'b0;
				end
				default:
				begin
					core_clk_en <= 1'b1;
					periph_clk_en <= 1'b1;
					fro_en <= 1'b1;
					fro_out_en <= 1'b1;
					low_power_oscillator_en <= 1'b1;
					xtal_en <= clk_req != lpw_pkg::CLK_FRO;
					pll_en <= clk_req == lpw_pkg::CLK_PLL;
					flash_en <= 1'b1;
					flash_standby <= 1'b0;
					analog_en <= 1'b1;
					bod_en <= 1'b1;
				end
			endcase
		end
	end
endmodule

/* dv/lpw_ctrl_monitor.sv */
// port assertions for the low-power mode controller
// assumes bind into lpw_ctrl, one clock pclk, reset presetn
module lpw_ctrl_monitor #(
	parameter int NPIN = 8,
	parameter int NIRQ = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic core_wfi,
	input wire logic [NIRQ-1:0] irq_pending,
	input wire logic [NIRQ-1:0] irq_enable,
	input wire logic xtal_ready,
	input wire logic pll_locked,
	input wire logic core_clk_en,
	input wire logic periph_clk_en,
	input wire logic fro_en,
	input wire logic fro_out_en,
	input wire logic xtal_en,
	input wire logic pll_en,
	input wire logic flash_en,
	input wire logic flash_standby,
	input wire logic analog_en,
	input wire logic wkt_start,
	input wire logic [1:0] main_clk_sel
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ==========================================
	// sequences
	sequence s_run_wfi;
		core_clk_en && core_wfi;
	endsequence
	// sleep is the only clock-gated state with flash on and not in standby
	sequence s_sleep_irq;
		!core_clk_en && flash_en && !flash_standby
			&& |(irq_pending & irq_enable);
	endsequence
	sequence s_cnt_wr;
		psel && penable && pwrite && paddr == lpw_pkg::ADDR_WKT_COUNT;
	endsequence

	// ==========================================
	// assertions
	AST_WFI_ENTER: assert property (s_run_wfi |=> !core_clk_en)
		else $error("core clock kept after wait request");
	AST_WFI_CAUSE: assert property ($fell(core_clk_en) |-> $past(core_wfi))
		else $error("core clock stopped without wait request");
	AST_SLEEP_WAKE: assert property (s_sleep_irq |-> ##[1:2] core_clk_en)
		else $error("enabled interrupt did not end sleep");
	AST_DS_GATE: assert property (flash_standby |-> !core_clk_en
		&& !periph_clk_en && !fro_out_en && !analog_en)
		else $error("deep-sleep gating wrong");
	AST_DS_SRC: assert property (flash_standby |-> fro_en
		&& !pll_en && !xtal_en)
		else $error("deep-sleep sources wrong");
	AST_WKT_START: assert property (s_cnt_wr |=> wkt_start)
		else $error("timer not started by count write");
	AST_WKT_PULSE: assert property (wkt_start |=> !wkt_start)
		else $error("timer start longer than one cycle");
	AST_PREADY: assert property (psel && penable |-> pready)
		else $error("bus not ready");
	AST_UNMAPPED: assert property (psel && penable
		&& paddr > 12'h028 |-> pslverr)
		else $error("unmapped access not flagged");
	AST_XTAL_SEL: assert property ($changed(main_clk_sel)
		&& main_clk_sel == lpw_pkg::CLK_XTAL |-> $past(xtal_ready))
		else $error("switched to crystal before ready");
	AST_PLL_SEL: assert property ($changed(main_clk_sel)
		&& main_clk_sel == lpw_pkg::CLK_PLL |-> $past(pll_locked))
		else $error("switched to pll before lock");
endmodule

bind lpw_ctrl lpw_ctrl_monitor #(.NPIN(NPIN), .NIRQ(NIRQ)) lpw_ctrl_monitor_i (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
	.core_wfi, .irq_pending, .irq_enable, .xtal_ready, .pll_locked,
	.core_clk_en, .periph_clk_en, .fro_en, .fro_out_en, .xtal_en, .pll_en,
	.flash_en, .flash_standby, .analog_en, .wkt_start, .main_clk_sel
);

/* dv/lpw_osc_model.sv */
// model of crystal oscillator and pll beside the controller
// assumes enables come from the controller in the pclk domain
module lpw_osc_model #(
	parameter int XTAL_START = 8,
	parameter int PLL_START = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic xtal_en,
	input wire logic pll_en,
	output logic xtal_ready,
	output logic pll_locked
);
	timeunit 1ns;
	timeprecision 100ps;
	int xc;
	int pc;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			xc <= 0;
			pc <= 0;
		end
		else
		begin
			xc <= xtal_en ? xc + (xc < XTAL_START) : 0;
			pc <= pll_en ? pc + (pc < PLL_START) : 0;
		end
	end
	// ready only after the start-up time
	assign xtal_ready = (xc == XTAL_START);
	assign pll_locked = (pc == PLL_START);
endmodule

/* dv/lpw_ctrl_test.sv */
// self-checking bench for the low-power mode controller
// assumes lpw_pkg compiled first, oscillator model beside the design
module lpw_ctrl_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_wfi;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, irq_pending, irq_enable;
	logic [7:0] pin_irq, pin_irq_en;
	logic bod_irq, bod_irq_en, bod_reset, wdt_irq, wdt_irq_en, wkt_timeout;
	logic wkt_irq_en, serial_irq, serial_irq_en, wake_pin, reset_pin_n;
	logic reset_pin_func_en, xtal_ready, pll_locked, core_clk_en;
	logic periph_clk_en, fro_en, fro_out_en, low_power_oscillator_en, xtal_en, pll_en;
	logic flash_en, flash_standby, analog_en, bod_en, wkt_en, wkt_start;
	logic wake_reset;
	logic [1:0] main_clk_sel;
	logic [10:0] outs;
	int n_errors, total_checks, cycles;

	assign outs = {core_clk_en, periph_clk_en, fro_en, fro_out_en, low_power_oscillator_en,
		xtal_en, pll_en, flash_en, flash_standby, analog_en, bod_en};

	lpw_ctrl #(.NPIN(8), .NIRQ(32)) lpw_ctrl_i (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.core_wfi, .irq_pending, .irq_enable, .pin_irq, .pin_irq_en,
		.bod_irq, .bod_irq_en, .bod_reset, .wdt_irq, .wdt_irq_en,
		.wkt_timeout, .wkt_irq_en, .serial_irq, .serial_irq_en, .wake_pin,
		.reset_pin_n, .reset_pin_func_en, .xtal_ready, .pll_locked,
		.core_clk_en, .periph_clk_en, .fro_en, .fro_out_en, .low_power_oscillator_en,
		.xtal_en, .pll_en, .flash_en, .flash_standby, .analog_en, .bod_en,
		.wkt_en, .wkt_start, .main_clk_sel, .wake_reset);
	lpw_osc_model lpw_osc_model_i (.pclk, .presetn, .xtal_en, .pll_en,
		.xtal_ready, .pll_locked);

	// ==========================================
	// helpers
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		// response and read data are taken at the access edge
		err = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk(e, a > 12'h028);
	endtask
	task automatic enter(input logic [1:0] m);
		wr(lpw_pkg::ADDR_MODE, {30'h0, m});
		@(posedge pclk);
		core_wfi <= 1'b1;
		@(posedge pclk);
		core_wfi <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic stay(input int n);
		repeat (n) @(posedge pclk);
		chk(core_clk_en, 1'b0);
	endtask
	task automatic wake(input int lim);
		int n;
		n = 0;
		while (core_clk_en !== 1'b1 && n < lim)
		begin
			@(posedge pclk);
			n++;
		end
		chk(core_clk_en, 1'b1);
	endtask
	task automatic sel(input logic [1:0] v, input logic [1:0] was);
		wr(lpw_pkg::ADDR_CLK_SEL, {30'h0, v});
		chk(main_clk_sel, was);
		repeat (40) @(posedge pclk);
		chk(main_clk_sel, v);
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset();
		chk(outs, 11'h7CB);
		chk(main_clk_sel, lpw_pkg::CLK_FRO);
		rdchk(lpw_pkg::ADDR_SLEEP_CFG, 32'h3FF);
		rdchk(12'h0FC, 32'h0);
	endtask
	task automatic t_sleep();
		irq_enable <= 32'h20;
		enter(lpw_pkg::MODE_SLEEP);
		chk(outs & 11'h60C, 11'h208);
		irq_pending <= 32'h10;
		stay(4);
		irq_pending <= 32'h30;
		wake(3);
		irq_pending <= 32'h0;
		reset_pin_func_en <= 1'b1;
		enter(lpw_pkg::MODE_SLEEP);
		reset_pin_n <= 1'b0;
		wake(6);
		reset_pin_n <= 1'b1;
	endtask
	task automatic t_deep_sleep();
		pin_irq_en <= 8'h04;
		pin_irq <= 8'h04;
		enter(lpw_pkg::MODE_DEEP_SLEEP);
		chk(outs & 11'h7F7, 11'h145);
		stay(4);
		wr(lpw_pkg::ADDR_PIN_WAKE, 32'h4);
		wake(6);
		pin_irq <= 8'h0;
		wr(lpw_pkg::ADDR_PERIPH_WAKE, 32'h8);
		serial_irq_en <= 1'b1;
		enter(lpw_pkg::MODE_DEEP_SLEEP);
		serial_irq <= 1'b1;
		wake(3);
		serial_irq <= 1'b0;
	endtask
	task automatic t_power_down();
		wr(lpw_pkg::ADDR_BROWNOUT, 32'h2);
		enter(lpw_pkg::MODE_POWER_DOWN);
		chk(outs, 11'h041);
		bod_reset <= 1'b1;
		wake(3);
		bod_reset <= 1'b0;
		wr(lpw_pkg::ADDR_SLEEP_CFG, 32'h3FC);
		wr(lpw_pkg::ADDR_PERIPH_WAKE, 32'h2);
		wr(lpw_pkg::ADDR_WDT_MODE, 32'hB);
		enter(lpw_pkg::MODE_POWER_DOWN);
		chk(outs, 11'h000);
		bod_reset <= 1'b1;
		wdt_irq_en <= 1'b1;
		wdt_irq <= 1'b1;
		stay(4);
		bod_reset <= 1'b0;
		wr(lpw_pkg::ADDR_SLEEP_CFG, 32'h3FF);
		wake(3);
		wdt_irq <= 1'b0;
		wr(lpw_pkg::ADDR_BROWNOUT, 32'h1);
		wr(lpw_pkg::ADDR_PERIPH_WAKE, 32'h1);
		bod_irq_en <= 1'b1;
		enter(lpw_pkg::MODE_POWER_DOWN);
		bod_irq <= 1'b1;
		wake(3);
		bod_irq <= 1'b0;
	endtask
	task automatic t_deep_pd();
		wr(lpw_pkg::ADDR_DPD_CTRL, 32'h0);
		wake_pin <= 1'b1;
		enter(lpw_pkg::MODE_DEEP_PD);
		chk(outs, 11'h000);
		stay(5);
		wr(lpw_pkg::ADDR_DPD_CTRL, 32'h1);
		wake(8);
		chk(wake_reset, 1'b1);
		@(posedge pclk);
		chk(wake_reset, 1'b0);
		wake_pin <= 1'b0;
		wr(lpw_pkg::ADDR_DPD_CTRL, 32'h10);
		enter(lpw_pkg::MODE_DEEP_PD);
		rdchk(lpw_pkg::ADDR_STATUS, 32'h9);
		chk(outs & 11'h60C, 11'h208);
		irq_pending <= 32'h20;
		wake(3);
		irq_pending <= 32'h0;
	endtask
	task automatic t_misc();
		sel(lpw_pkg::CLK_XTAL, lpw_pkg::CLK_FRO);
		sel(lpw_pkg::CLK_PLL, lpw_pkg::CLK_XTAL);
		wr(lpw_pkg::ADDR_WKT_CTRL, 32'h1);
		wr(lpw_pkg::ADDR_WKT_COUNT, 32'h40);
		@(posedge pclk);
		chk(wkt_start, 1'b1);
		@(posedge pclk);
		chk(wkt_start, 1'b0);
		chk(wkt_en, 1'b1);
		wr(lpw_pkg::ADDR_DPD_CTRL, 32'hC);
		enter(lpw_pkg::MODE_DEEP_PD);
		chk(outs, 11'h040);
		wkt_timeout <= 1'b1;
		wake(3);
		chk(wake_reset, 1'b1);
		wkt_timeout <= 1'b0;
		wr(lpw_pkg::ADDR_PERIPH_WAKE, 32'h4);
		wkt_irq_en <= 1'b1;
		enter(lpw_pkg::MODE_POWER_DOWN);
		wkt_timeout <= 1'b1;
		wake(3);
		wkt_timeout <= 1'b0;
	endtask

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			finish_test();
		end
	end
	initial
	begin
		{presetn, psel, penable, pwrite, core_wfi, bod_irq, bod_irq_en} = '0;
		{bod_reset, wdt_irq, wdt_irq_en, wkt_timeout, wkt_irq_en} = '0;
		{serial_irq, serial_irq_en, wake_pin, reset_pin_func_en} = '0;
		{paddr, pwdata, irq_pending, irq_enable, pin_irq, pin_irq_en} = '0;
		reset_pin_n = 1'b1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_sleep();
		t_deep_sleep();
		t_power_down();
		t_deep_pd();
		t_misc();
		finish_test();
	end
endmodule
